// ### rtl/stc_pin_sync.sv
// three stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module stc_pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] pin_level
);
    import stc_pkg::*;

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("stc_pin_sync: WIDTH must be at least 1");
    end

    // ------------------------------------------------------------
    // per bit stages
    // ------------------------------------------------------------
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        logic [STC_SYNC_STAGES-1:0] stage;

        // first stage feeds only the second
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stage <= '0;
            end else begin
                stage <= {stage[STC_SYNC_STAGES-2:0], pin_async[b]};
            end
        end

        // change counts only once stages two and three agree
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pin_level[b] <= 1'b0;
            end else if (stage[1] == stage[2]) begin
                pin_level[b] <= stage[2];
            end
        end
    end

endmodule // stc_pin_sync

// ### rtl/stc_pkg.sv
// shared constants for the sixteen bit timer counter
package stc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] STC_OFF_FLAGS      = 12'h00C;
    localparam logic [11:0] STC_OFF_CTRL       = 12'h010;
    localparam logic [11:0] STC_OFF_COUNT_LOW  = 12'h014;
    localparam logic [11:0] STC_OFF_COUNT_HIGH = 12'h018;
    localparam logic [11:0] STC_OFF_FLAG_CLEAR = 12'h01C;
    localparam logic [11:0] STC_OFF_ENABLES    = 12'h08C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned STC_CTRL_RUN_BIT    = 0;
    localparam int unsigned STC_CTRL_SRC_BIT    = 1;
    localparam int unsigned STC_CTRL_NOSYNC_BIT = 2;
    localparam int unsigned STC_CTRL_OSC_BIT    = 3;
    localparam int unsigned STC_CTRL_PS_LSB     = 4;
    localparam int unsigned STC_CTRL_PS_MSB     = 5;
    localparam int unsigned STC_FLAG_OVF_BIT    = 0;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0]  STC_CTRL_RESET   = 8'h00;
    localparam logic [7:0]  STC_CTRL_MASK    = 8'h3F;
    localparam logic [7:0]  STC_FLAGS_RESET  = 8'h00;
    localparam logic [7:0]  STC_ENABLE_RESET = 8'h00;
    localparam logic [15:0] STC_COUNT_RESET  = 16'h0000;
    localparam logic [15:0] STC_COUNT_MAX    = 16'hFFFF;

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    // instruction cycle is the bus clock divided by four
    localparam int unsigned STC_CYCLE_DIV   = 4;
    localparam int unsigned STC_SYNC_STAGES = 3;

endpackage // stc_pkg

// ### rtl/stc_timer.sv
// sixteen bit timer counter with apb register slave
// ------------------------------------------------------------
// Notes on behaviour
// - sixteen bit up-counter in two writable bytes, wraps FFFF to 0000
// - every wrap sets the sticky overflow flag at flag bit zero
// - interrupt raised only while overflow enable bit zero is set
// - control bit 1 picks external pin edges, else bus clock over four
// - timer mode steps per instruction cycle, counter mode per rising edge
// - control bit 0 runs the counter, clear holds its value
// - control bits 5-4 prescale the chosen clock 1, 2, 4 or 8
// - control bit 2 skips edge alignment, only with external clock
// - control bit 3 powers the low-power oscillator, clear shuts it off
// - accepts a counter reset from either capture/compare unit
// - oscillator enabled forces both oscillator pins to input
// - control bits 7-6 ignore writes and read as zero
// - control bits reset to zero: stopped, internal clock, 1:1, osc off
// ------------------------------------------------------------
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
module stc_timer #(
    parameter int unsigned CYCLE_DIV       = stc_pkg::STC_CYCLE_DIV,
    parameter bit          OSC_FORCES_BOTH = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        osc_out_clock_in_pin,
    input  wire logic        ccp1_counter_reset,
    input  wire logic        ccp2_counter_reset,
    input  wire logic [1:0]  port_direction_bits,
    output logic      [1:0]  pin_direction_input,
    output logic             low_power_osc_on,
    output logic             irq
);
    import stc_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (CYCLE_DIV < 2) begin : g_bad_div
        $error("stc_timer: CYCLE_DIV must be at least 2");
    end

    localparam int unsigned CW = (CYCLE_DIV > 2) ? $clog2(CYCLE_DIV) : 1;
    localparam logic [CW-1:0] CYC_LAST = CW'(CYCLE_DIV - 1);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0]    counter_control;
    logic [7:0]    peripheral_irq_flags;
    logic [7:0]    peripheral_irq_enables;
    logic [7:0]    count_low_byte;
    logic [7:0]    count_high_byte;
    logic [15:0]   count_value;
    logic [CW-1:0] cycle_phase;
    logic [2:0]    prescale_count;
    logic [2:0]    prescale_last;
    logic          ext_level;
    logic          ext_prev;
    logic          ext_rise;
    logic          ext_pending;
    logic          ext_aligned;
    logic          cycle_tick;
    logic          source_event;
    logic          prescale_event;
    logic          count_event;
    logic          overflow_set;
    logic          ccp_reset;
    logic          run_control;
    logic          clock_source_select;
    logic          ext_sync_disable;
    logic          low_power_osc_enable;
    logic [1:0]    prescale_select;
    logic          setup_phase;
    logic          access_phase;
    logic          write_lane0;
    logic          addr_mapped;
    logic          wr_ctrl;
    logic          wr_low;
    logic          wr_high;
    logic          wr_clear;
    logic          wr_enables;
    logic          count_written;
    logic [7:0]    read_byte;

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    assign run_control          = counter_control[STC_CTRL_RUN_BIT];
    assign clock_source_select  = counter_control[STC_CTRL_SRC_BIT];
    assign ext_sync_disable     = counter_control[STC_CTRL_NOSYNC_BIT];
    assign low_power_osc_enable = counter_control[STC_CTRL_OSC_BIT];
    assign prescale_select      = counter_control[STC_CTRL_PS_MSB:STC_CTRL_PS_LSB];
    assign count_value          = {count_high_byte, count_low_byte};

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    // zero wait states: read data was captured in the setup cycle
    assign pready       = access_phase;
    // lanes above zero are unused: each register is one byte
    assign write_lane0  = access_phase & pwrite & pstrb[0];

    always_comb begin
        case (paddr)
            STC_OFF_FLAGS,
            STC_OFF_CTRL,
            STC_OFF_COUNT_LOW,
            STC_OFF_COUNT_HIGH,
            STC_OFF_FLAG_CLEAR,
            STC_OFF_ENABLES: addr_mapped = 1'b1;
            default:         addr_mapped = 1'b0;
        endcase
    end

    assign wr_ctrl    = write_lane0 & (paddr == STC_OFF_CTRL);
    assign wr_low     = write_lane0 & (paddr == STC_OFF_COUNT_LOW);
    assign wr_high    = write_lane0 & (paddr == STC_OFF_COUNT_HIGH);
    assign wr_clear   = write_lane0 & (paddr == STC_OFF_FLAG_CLEAR);
    assign wr_enables = write_lane0 & (paddr == STC_OFF_ENABLES);
    assign count_written = wr_low | wr_high;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // write-only clear register reads as zero
    always_comb begin
        case (paddr)
            STC_OFF_FLAGS:      read_byte = peripheral_irq_flags;
            STC_OFF_CTRL:       read_byte = counter_control;
            STC_OFF_COUNT_LOW:  read_byte = count_low_byte;
            STC_OFF_COUNT_HIGH: read_byte = count_high_byte;
            STC_OFF_ENABLES:    read_byte = peripheral_irq_enables;
            default:            read_byte = 8'h00;
        endcase
    end

    // data and error are registered at the setup edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= pwrite ? 32'h00000000 : {24'h000000, read_byte};
            pslverr <= ~addr_mapped;
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_control <= STC_CTRL_RESET;
        end else if (wr_ctrl) begin
            counter_control <= pwdata[7:0] & STC_CTRL_MASK;
        end
    end

    // ------------------------------------------------------------
    // oscillator and pin direction
    // ------------------------------------------------------------
    // oscillator power switch
    assign low_power_osc_on = low_power_osc_enable;

    // legacy variant leaves pin zero to software
    assign pin_direction_input[1] = low_power_osc_enable | port_direction_bits[1];
    assign pin_direction_input[0] = (low_power_osc_enable & OSC_FORCES_BOTH)
                                  | port_direction_bits[0];

    // ------------------------------------------------------------
    // instruction cycle phase
    // ------------------------------------------------------------
    // free running so timer mode keeps its phase while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_phase <= '0;
        end else if (cycle_phase == CYC_LAST) begin
            cycle_phase <= '0;
        end else begin
            cycle_phase <= cycle_phase + CW'(1);
        end
    end

    assign cycle_tick = (cycle_phase == CYC_LAST);

    // ------------------------------------------------------------
    // external clock input
    // ------------------------------------------------------------
    stc_pin_sync #(
        .WIDTH     (1)
    ) u_pin_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (osc_out_clock_in_pin),
        .pin_level (ext_level)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_level;
        end
    end

    assign ext_rise = ext_level & ~ext_prev;

    // aligned mode holds an edge until the next cycle boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_pending <= 1'b0;
        end else if (cycle_tick) begin
            ext_pending <= 1'b0;
        end else if (ext_rise) begin
            ext_pending <= 1'b1;
        end
    end

    assign ext_aligned = cycle_tick & (ext_pending | ext_rise);

    // ------------------------------------------------------------
    // clock selection
    // ------------------------------------------------------------
    always_comb begin
        if (clock_source_select) begin
            source_event = ext_sync_disable ? ext_rise : ext_aligned;
        end else begin
            // internal source ignores the sync bit
            source_event = cycle_tick;
        end
    end

    assign prescale_event = run_control & source_event;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    // ratio decode
    always_comb begin
        case (prescale_select)
            2'b00:   prescale_last = 3'h0;
            2'b01:   prescale_last = 3'h1;
            2'b10:   prescale_last = 3'h3;
            2'b11:   prescale_last = 3'h7;
            default: prescale_last = 3'h0;
        endcase
    end

    assign ccp_reset   = ccp1_counter_reset | ccp2_counter_reset;
    assign count_event = prescale_event & (prescale_count >= prescale_last);

    // a count write also clears the partial prescale count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_count <= 3'h0;
        end else if (count_written || ccp_reset) begin
            prescale_count <= 3'h0;
        end else if (count_event) begin
            prescale_count <= 3'h0;
        end else if (prescale_event) begin
            prescale_count <= prescale_count + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // counter halves
    // ------------------------------------------------------------
    // halves are not latched: low then high may straddle a carry
    // software write beats a capture/compare reset and a count step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_low_byte  <= STC_COUNT_RESET[7:0];
            count_high_byte <= STC_COUNT_RESET[15:8];
        end else if (count_written) begin
            if (wr_low) begin
                count_low_byte <= pwdata[7:0];
            end
            if (wr_high) begin
                count_high_byte <= pwdata[7:0];
            end
        end else if (ccp_reset) begin
            count_low_byte  <= STC_COUNT_RESET[7:0];
            count_high_byte <= STC_COUNT_RESET[15:8];
        end else if (count_event) begin
            {count_high_byte, count_low_byte} <= count_value + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // overflow flag and interrupt
    // ------------------------------------------------------------
    assign overflow_set = count_event & ~count_written & ~ccp_reset
                        & (count_value == STC_COUNT_MAX);

    // set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_irq_flags <= STC_FLAGS_RESET;
        end else if (overflow_set) begin
            peripheral_irq_flags[STC_FLAG_OVF_BIT] <= 1'b1;
        end else if (wr_clear && pwdata[STC_FLAG_OVF_BIT]) begin
            peripheral_irq_flags[STC_FLAG_OVF_BIT] <= 1'b0;
        end
    end

    // only the overflow enable is implemented
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_irq_enables <= STC_ENABLE_RESET;
        end else if (wr_enables) begin
            peripheral_irq_enables[STC_FLAG_OVF_BIT] <= pwdata[STC_FLAG_OVF_BIT];
        end
    end

    assign irq = |(peripheral_irq_flags & peripheral_irq_enables);

endmodule // stc_timer

// ### verif/stc_ext_src.sv
// external clock source model for the counter pin
`timescale 1ns/100ps
module stc_ext_src (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic [7:0] edges,
    input  wire logic [3:0] half,
    output logic            pin,
    output logic            busy
);
    logic [7:0] left;
    logic [3:0] cnt;
    // ----
    // burst of rising edges
    // ----
    // rising edges counted
    // pin stands low between bursts; half sets prompt or slow rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin <= 1'b0;
            busy <= 1'b0;
            left <= 8'h00;
            cnt <= 4'h0;
        end else if (start && !busy) begin
            busy <= 1'b1;
            left <= edges;
            cnt <= half;
        end else if (busy && cnt > 4'h1) begin
            cnt <= cnt - 4'h1;
        end else if (busy) begin
            cnt <= half;
            if (!pin && left == 8'h00) begin
                busy <= 1'b0;
            end else begin
                pin <= !pin;
                left <= pin ? left : left - 8'h01;
            end
        end
    end
endmodule // stc_ext_src

// ### verif/stc_timer_monitor.sv
// port level checks for the timer counter
`timescale 1ns/100ps
module stc_timer_monitor #(
    parameter bit OSC_FORCES_BOTH = 1'b1
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  port_direction_bits,
    input wire logic [1:0]  pin_direction_input,
    input wire logic        low_power_osc_on,
    input wire logic        irq
);
    import stc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic rd;
    logic wr;
    logic mapped;
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign wr = acc && pwrite && pstrb[0];
    assign mapped = paddr inside {STC_OFF_FLAGS, STC_OFF_CTRL, STC_OFF_COUNT_LOW,
                                  STC_OFF_COUNT_HIGH, STC_OFF_FLAG_CLEAR, STC_OFF_ENABLES};
    // ----
    // bus answer
    // ----
    a_ready_access: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_ready_idle: assert property (!acc |-> !pready)
        else $error("pready high outside access phase");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access flagged as error");
    // ----
    // control, pins and interrupt
    // ----
    a_ctrl_top_zero: assert property (rd && paddr == STC_OFF_CTRL |-> prdata[31:6] == '0)
        else $error("control upper bits not zero");
    a_osc_read_match: assert property (
        rd && paddr == STC_OFF_CTRL |-> prdata[STC_CTRL_OSC_BIT] == low_power_osc_on)
        else $error("oscillator bit differs from output");
    a_osc_follows_write: assert property (
        wr && paddr == STC_OFF_CTRL |=> low_power_osc_on == $past(pwdata[STC_CTRL_OSC_BIT]))
        else $error("oscillator enable not taken from write");
    a_osc_holds: assert property (!(wr && paddr == STC_OFF_CTRL) |=> $stable(low_power_osc_on))
        else $error("oscillator enable changed without write");
    a_osc_pins_in: assert property (low_power_osc_on |->
        pin_direction_input == {1'b1, OSC_FORCES_BOTH ? 1'b1 : port_direction_bits[0]})
        else $error("oscillator pins not forced to input");
    a_dir_pass: assert property (!low_power_osc_on |->
        pin_direction_input == port_direction_bits)
        else $error("direction bits not passed through");
    a_irq_masked: assert property (
        wr && paddr == STC_OFF_ENABLES && !pwdata[0] |=> !irq [*3])
        else $error("interrupt raised while disabled");
    a_irq_read_en: assert property (rd && paddr == STC_OFF_ENABLES && !prdata[0] |-> !irq)
        else $error("interrupt high with enable clear");
    c_osc_on: cover property (wr && paddr == STC_OFF_CTRL && pwdata[STC_CTRL_OSC_BIT]);
    c_unmapped: cover property (acc && !mapped);
    c_irq_rise: cover property ($rose(irq));
endmodule // stc_timer_monitor

// ### verif/stc_timer_tb.sv
// self-checking bench for the timer counter
`timescale 1ns/100ps
module stc_timer_tb;
    import stc_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_pin;
    logic        src_busy;
    logic        src_start = 1'b0;
    logic [7:0]  src_edges = 8'h08;
    logic [3:0]  src_half = 4'h3;
    logic        ccp1_counter_reset = 1'b0;
    logic        ccp2_counter_reset = 1'b0;
    logic [1:0]  port_direction_bits = 2'b00;
    logic [1:0]  pin_direction_input;
    logic        low_power_osc_on;
    logic        irq;
    logic [31:0] seed = 32'h3159;
    logic [31:0] rv;
    logic [31:0] q;
    logic [31:0] held;
    logic        err_seen;
    int          errors = 0;
    int          samples_checked = 0;

    always #10 pclk = ~pclk;

    stc_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_out_clock_in_pin(ext_pin),
        .ccp1_counter_reset(ccp1_counter_reset), .ccp2_counter_reset(ccp2_counter_reset),
        .port_direction_bits(port_direction_bits), .pin_direction_input(pin_direction_input),
        .low_power_osc_on(low_power_osc_on), .irq(irq));
    stc_ext_src u_src (.pclk(pclk), .presetn(presetn), .start(src_start), .edges(src_edges),
        .half(src_half), .pin(ext_pin), .busy(src_busy));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // ----
    // bus tasks and comparisons
    // ----
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 4'hF);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(a, 1'b0, 32'h0, 4'hF);
    endtask
    // near: the free tick phase allows one count either way
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g,
                       input bit near = 1'b0);
        samples_checked++;
        if (g !== e && !(near && (g === e + 1 || g === e - 1))) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ----
    // test sequence
    // ----
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(STC_OFF_CTRL);
        chk("control reset", 32'h0, q);
        rd(STC_OFF_FLAGS);
        chk("flags reset", 32'h0, q);
        rd(STC_OFF_ENABLES);
        chk("enables reset", 32'h0, q);
        rd(STC_OFF_COUNT_LOW);
        chk("count reset", 32'h0, q);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            rv = xs();
            port_direction_bits <= rv[9:8];
            wr(STC_OFF_CTRL, rv);
            rd(STC_OFF_CTRL);
            chk("control", 32'(rv[5:0]), q);
            @(negedge pclk);
            chk("osc on", 32'(rv[3]), 32'(low_power_osc_on));
            chk("pin dir", 32'(rv[3] ? 2'b11 : rv[9:8]), 32'(pin_direction_input));
        end
        wr(STC_OFF_CTRL, 32'h0);
        rv = xs();
        wr(STC_OFF_COUNT_HIGH, 32'(rv[15:8]));
        wr(STC_OFF_COUNT_LOW, 32'(rv[7:0]));
        apb(STC_OFF_COUNT_LOW, 1'b1, ~rv, 4'h0);
        rd(STC_OFF_COUNT_LOW);
        chk("count low", 32'(rv[7:0]), q);
        rd(STC_OFF_COUNT_HIGH);
        chk("count high", 32'(rv[15:8]), q);
        rd(12'h040);
        chk("unmapped error", 32'h1, 32'(err_seen));
        $display("test registers done");
        for (int ps = 0; ps < 4; ps++) begin
            wr(STC_OFF_COUNT_LOW, 32'h0);
            wr(STC_OFF_COUNT_HIGH, 32'h0);
            wr(STC_OFF_CTRL, 32'((ps << 4) | ((ps & 1) << 2) | 1));
            repeat (200) @(posedge pclk);
            wr(STC_OFF_CTRL, 32'(ps << 4));
            rd(STC_OFF_COUNT_LOW);
            held = q;
            chk("timer count", 32'(203 / (4 << ps)), q, 1'b1);
            repeat (30) @(posedge pclk);
            rd(STC_OFF_COUNT_LOW);
            chk("held count", held, q);
        end
        $display("test prescale done");
        wr(STC_OFF_ENABLES, 32'h0);
        wr(STC_OFF_COUNT_HIGH, 32'hFF);
        wr(STC_OFF_COUNT_LOW, 32'hFC);
        wr(STC_OFF_CTRL, 32'h1);
        repeat (40) @(posedge pclk);
        wr(STC_OFF_CTRL, 32'h0);
        rd(STC_OFF_FLAGS);
        chk("overflow flag", 32'h1, q);
        chk("masked irq", 32'h0, 32'(irq));
        rd(STC_OFF_COUNT_HIGH);
        chk("wrapped high", 32'h0, q);
        rd(STC_OFF_COUNT_LOW);
        chk("wrapped low", 32'h6, q, 1'b1);
        wr(STC_OFF_ENABLES, 32'h1);
        @(negedge pclk);
        chk("enabled irq", 32'h1, 32'(irq));
        wr(STC_OFF_FLAGS, 32'h0);
        rd(STC_OFF_FLAGS);
        chk("flag kept", 32'h1, q);
        wr(STC_OFF_FLAG_CLEAR, 32'h1);
        rd(STC_OFF_FLAGS);
        chk("flag cleared", 32'h0, q);
        @(negedge pclk);
        chk("irq cleared", 32'h0, 32'(irq));
        $display("test overflow done");
        // software makes the clock pin an input
        port_direction_bits <= 2'b01;
        for (int i = 0; i < 4; i++) begin
            wr(STC_OFF_COUNT_LOW, 32'h0);
            wr(STC_OFF_COUNT_HIGH, 32'h0);
            wr(STC_OFF_CTRL, 32'(((i & 2) << 3) | ((i & 1) << 2) | (i == 3 ? 11 : 3)));
            src_half <= (i & 1) ? 4'h3 : 4'h7;
            src_start <= 1'b1;
            @(posedge pclk);
            src_start <= 1'b0;
            @(posedge pclk);
            while (src_busy !== 1'b0) @(posedge pclk);
            repeat (20) @(posedge pclk);
            wr(STC_OFF_CTRL, 32'h0);
            rd(STC_OFF_COUNT_LOW);
            chk("edge count", 32'(8 >> (i >> 1)), q);
        end
        $display("test counter done");
        for (int i = 0; i < 2; i++) begin
            wr(STC_OFF_COUNT_LOW, xs() | 32'h1);
            ccp1_counter_reset <= (i == 0);
            ccp2_counter_reset <= (i == 1);
            @(posedge pclk);
            ccp1_counter_reset <= 1'b0;
            ccp2_counter_reset <= 1'b0;
            rd(STC_OFF_COUNT_LOW);
            chk("ccp cleared", 32'h0, q);
        end
        $display("test ccp reset done");
        tally_and_finish();
    end

    initial begin
        repeat (30000) @(posedge pclk);
        errors++;
        tally_and_finish();
    end
endmodule // stc_timer_tb

bind stc_timer stc_timer_monitor #(.OSC_FORCES_BOTH(OSC_FORCES_BOTH)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_power_osc_on(low_power_osc_on), .irq(irq),
    .port_direction_bits(port_direction_bits), .pin_direction_input(pin_direction_input));
